// ---- design/host_port_mode_select.sv ----
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_mode_select_regs.svh"

module host_port_mode_select
	import host_port_mode_select_pkg::*;
#(
	parameter int EVENT_W = 8
) (
	input wire logic core_clk, // 100 MHz clock
	input wire logic reset, // Sync reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire pin_in_t pinIn, // Raw pin levels
	output logic bit7Out, // Bit-7 pin drive value
	output logic bit7OeN, // Bit-7 pin enable, low drives
	output logic intOut, // Interrupt pin drive value
	output logic intOeN, // Interrupt pin enable, low drives
	input wire logic coreData7Out, // Core data bit 7 to pin
	input wire logic coreData7Drive, // Core wants to drive bit 7
	output logic coreData7In, // Bit 7 from data phase
	output logic coreAddr7, // Latched address bit 7
	input wire logic [EVENT_W-1:0] eventIn, // Event pulses
	output cfg_out_t cfgOut, // Mode and config levels
	output logic regReset, // Register set reset pulse
	output logic irq // Internal interrupt level
);

	// Status, enable and read data share one 32-bit word
	if (EVENT_W < 1 || EVENT_W > 32) begin : g_badWidth
		$error("EVENT_W must be 1 to 32");
	end

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	pin_in_t meta_q;
	pin_in_t sync_q;
	logic tstPrev_q;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			meta_q <= '0;
			sync_q <= '0;
			tstPrev_q <= 1'b0;
		end else begin
			meta_q <= pinIn;
			sync_q <= meta_q;
			tstPrev_q <= sync_q.tristateResetPin;
		end
	end

	bus_mode_t mode;
	logic tristate;
	logic hwMode;

	always_comb begin
		mode = bus_mode_t'(sync_q.busIfaceSelect);
		hwMode = (mode == MODE_HW);
		tristate = sync_q.tristateResetPin;
		regReset = sync_q.tristateResetPin & ~tstPrev_q;
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [EVENT_W-1:0] status_q, status_d;
	logic [EVENT_W-1:0] enable_q, enable_d;
	logic [1:0] ctrl_q, ctrl_d;
	logic [31:0] prdata_q, prdata_d;
	logic ready_q, ready_d;
	logic err_q, err_d;
	logic [EVENT_W-1:0] clearMask;
	logic access;
	logic hit;
	logic [31:0] rdVal;

	always_comb begin
		access = psel & penable & ~ready_q;
		hit = 1'b1;
		rdVal = 32'h0000_0000;
		unique case (paddr)
			`HPMS_STATUS_OFF: rdVal[EVENT_W-1:0] = status_q;
			`HPMS_ENABLE_OFF: rdVal[EVENT_W-1:0] = enable_q;
			`HPMS_CLEAR_OFF: rdVal = 32'h0000_0000;
			`HPMS_CTRL_OFF: rdVal[`HPMS_CTRL_TXMODE_LSB +: 2] = ctrl_q;
			`HPMS_PINS_OFF: begin
				rdVal[`HPMS_PINS_SEL_LSB +: 2] = sync_q.busIfaceSelect;
				rdVal[`HPMS_PINS_TST_BIT] = sync_q.tristateResetPin;
				rdVal[`HPMS_PINS_BIT7_BIT] = sync_q.bit7;
				rdVal[`HPMS_PINS_JACK_BIT] = sync_q.jitterClkSelect0;
				rdVal[`HPMS_PINS_TXM_LSB +: 2] = cfgOut.txMode;
			end
			default: hit = 1'b0;
		endcase
		ready_d = access;
		err_d = access & ~hit;
		prdata_d = prdata_q;
		if (access && !pwrite) begin
			prdata_d = hit ? rdVal : 32'h0000_0000;
		end
		clearMask = '0;
		enable_d = enable_q;
		ctrl_d = ctrl_q;
		if (access && pwrite) begin
			unique case (paddr)
				`HPMS_ENABLE_OFF: enable_d = pwdata[EVENT_W-1:0];
				`HPMS_CLEAR_OFF: clearMask = pwdata[EVENT_W-1:0];
				`HPMS_CTRL_OFF: ctrl_d = pwdata[`HPMS_CTRL_TXMODE_LSB +: 2];
				default: ;
			endcase
		end
		// A new event beats a clear in the same cycle
		status_d = (status_q & ~clearMask) | eventIn;
		if (regReset) begin
			status_d = '0;
			enable_d = EVENT_W'(`HPMS_ENABLE_RST);
			ctrl_d = `HPMS_CTRL_RST;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			status_q <= '0;
			enable_q <= EVENT_W'(`HPMS_ENABLE_RST);
			ctrl_q <= `HPMS_CTRL_RST;
			prdata_q <= 32'h0000_0000;
			ready_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			status_q <= status_d;
			enable_q <= enable_d;
			ctrl_q <= ctrl_d;
			prdata_q <= prdata_d;
			ready_q <= ready_d;
			err_q <= err_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = ready_q;
	assign pslverr = err_q;

	// ****************************************************************
	// Multiplexed address capture
	// ****************************************************************
	// Address bit is taken while the latch strobe is high in mode 00
	logic addr7_q, addr7_d;
	logic data7_q, data7_d;

	always_comb begin
		addr7_d = addr7_q;
		data7_d = data7_q;
		if (mode == MODE_MUX && sync_q.addrLatch) begin
			addr7_d = sync_q.bit7;
		end else if (mode == MODE_MUX || mode == MODE_NONMUX) begin
			data7_d = sync_q.bit7;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			addr7_q <= 1'b0;
			data7_q <= 1'b0;
		end else begin
			addr7_q <= addr7_d;
			data7_q <= data7_d;
		end
	end

	assign coreAddr7 = addr7_q;
	assign coreData7In = data7_q;

	// ****************************************************************
	// Pin drivers and configuration outputs
	// ****************************************************************
	// Hardware-mode straps are trusted to be static; only synced copies
	// reach logic, so a strap change takes two cycles to be seen.
	always_comb begin
		irq = |(status_q & enable_q);
		bit7Out = coreData7Out;
		bit7OeN = 1'b1;
		// Only the muxed bus uses the strobe; mode 01 ignores it
		if (!tristate && coreData7Drive && (mode == MODE_NONMUX
				|| (mode == MODE_MUX && !sync_q.addrLatch))) begin
			bit7OeN = 1'b0;
		end
		intOut = 1'b0;
		intOeN = ~(irq & ~hwMode & ~tristate);
		cfgOut.rxTermDisable = hwMode & sync_q.bit7;
		cfgOut.txMode = hwMode ?
			{sync_q.txModeSelect2, sync_q.txModeSelect1} : ctrl_q;
		// Host must strap this high for T1 with E1-family master clocks
		cfgOut.jitterClkSelect0 = hwMode & sync_q.jitterClkSelect0;
		cfgOut.tristateAll = tristate;
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_modeDecode;
		@(posedge core_clk) disable iff (reset)
		(sync_q.busIfaceSelect == 2'h3) |-> hwMode;
	endproperty
	a_modeDecode: assert property (p_modeDecode)
		else $error("select 11 not decoded as hardware mode");

	property p_nonmuxDrive;
		@(posedge core_clk) disable iff (reset)
		(mode == MODE_NONMUX && coreData7Drive && !tristate)
			|-> (!bit7OeN && bit7Out == coreData7Out);
	endproperty
	a_nonmuxDrive: assert property (p_nonmuxDrive)
		else $error("bit 7 not driven in nonmultiplexed mode");

	property p_muxAddr;
		@(posedge core_clk) disable iff (reset)
		(mode == MODE_MUX && sync_q.addrLatch)
			|=> (coreAddr7 == $past(sync_q.bit7));
	endproperty
	a_muxAddr: assert property (p_muxAddr)
		else $error("address bit 7 not captured");

	property p_rxTerm;
		@(posedge core_clk) disable iff (reset)
		cfgOut.rxTermDisable == (hwMode && sync_q.bit7 && bit7OeN);
	endproperty
	a_rxTerm: assert property (p_rxTerm)
		else $error("receive termination disable wrong");

	property p_txMode;
		@(posedge core_clk) disable iff (reset)
		hwMode |-> cfgOut.txMode ==
			{sync_q.txModeSelect2, sync_q.txModeSelect1};
	endproperty
	a_txMode: assert property (p_txMode)
		else $error("transmit mode not from pins in hardware mode");

	property p_regReset;
		@(posedge core_clk) disable iff (reset)
		$rose(sync_q.tristateResetPin)
			|=> (enable_q == '0 && ctrl_q == 2'h0 && !irq);
	endproperty
	a_regReset: assert property (p_regReset)
		else $error("registers not reset on tristate pin rise");

	property p_tristate;
		@(posedge core_clk) disable iff (reset)
		tristate |-> (bit7OeN && intOeN);
	endproperty
	a_tristate: assert property (p_tristate)
		else $error("pin driven while tristate pin high");

	property p_intPull;
		@(posedge core_clk) disable iff (reset)
		(irq && !hwMode && !tristate) |-> (!intOeN && !intOut);
	endproperty
	a_intPull: assert property (p_intPull)
		else $error("interrupt pin not pulled low");

	property p_jackInput;
		@(posedge core_clk) disable iff (reset)
		hwMode |-> (intOeN &&
			cfgOut.jitterClkSelect0 == sync_q.jitterClkSelect0);
	endproperty
	a_jackInput: assert property (p_jackInput)
		else $error("interrupt pin not an input in hardware mode");

	property p_apbAnswer;
		@(posedge core_clk) disable iff (reset)
		(psel && penable && !pready) |=> pready ##1 !pready;
	endproperty
	a_apbAnswer: assert property (p_apbAnswer)
		else $error("APB answer not one cycle after access");

	property p_eventWins;
		@(posedge core_clk) disable iff (reset)
		(eventIn != '0 && !regReset)
			|=> ((status_q & $past(eventIn)) == $past(eventIn));
	endproperty
	a_eventWins: assert property (p_eventWins)
		else $error("event lost against a clear");

	property p_clearWorks;
		@(posedge core_clk) disable iff (reset)
		(psel && penable && !pready && pwrite
			&& paddr == `HPMS_CLEAR_OFF)
			|=> ((status_q & $past(pwdata[EVENT_W-1:0])
				& ~$past(eventIn)) == '0);
	endproperty
	a_clearWorks: assert property (p_clearWorks)
		else $error("status bit not cleared by clear write");

	property p_regResetPulse;
		@(posedge core_clk) disable iff (reset)
		regReset |=> !regReset;
	endproperty
	a_regResetPulse: assert property (p_regResetPulse)
		else $error("register reset pulse longer than one cycle");

	property p_busRelease;
		@(posedge core_clk) disable iff (reset)
		(mode == MODE_SERIAL || hwMode) |-> bit7OeN;
	endproperty
	a_busRelease: assert property (p_busRelease)
		else $error("bit 7 driven outside parallel modes");

endmodule
`default_nettype wire

// ---- design/host_port_mode_select_pkg.sv ----
package host_port_mode_select_pkg;

	typedef enum logic [1:0] {
		MODE_MUX = 2'h0,
		MODE_NONMUX = 2'h1,
		MODE_SERIAL = 2'h2,
		MODE_HW = 2'h3
	} bus_mode_t;

	// Pins sampled from outside the clock domain
	typedef struct packed {
		logic [1:0] busIfaceSelect;
		logic tristateResetPin;
		logic txModeSelect1;
		logic txModeSelect2;
		logic bit7;
		logic jitterClkSelect0;
		logic addrLatch;
	} pin_in_t;

	typedef struct packed {
		logic rxTermDisable;
		logic [1:0] txMode;
		logic jitterClkSelect0;
		logic tristateAll;
	} cfg_out_t;

endpackage

// ---- design/host_port_mode_select_regs.svh ----
`ifndef HOST_PORT_MODE_SELECT_REGS_SVH
`define HOST_PORT_MODE_SELECT_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define HPMS_STATUS_OFF 12'h000
`define HPMS_ENABLE_OFF 12'h004
`define HPMS_CLEAR_OFF 12'h008
`define HPMS_CTRL_OFF 12'h00C
`define HPMS_PINS_OFF 12'h010

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define HPMS_CTRL_TXMODE_LSB 0
`define HPMS_PINS_SEL_LSB 0
`define HPMS_PINS_TST_BIT 2
`define HPMS_PINS_BIT7_BIT 3
`define HPMS_PINS_JACK_BIT 4
`define HPMS_PINS_TXM_LSB 5
`define HPMS_ENABLE_RST 32'h0000_0000
`define HPMS_CTRL_RST 2'h0

`endif

// ---- dv/host_pins_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_pins_model
	import host_port_mode_select_pkg::*;
(
	input wire logic [1:0] sel, // Interface strap
	input wire logic tst, // Tristate/reset level
	input wire logic [1:0] txm, // Transmit mode straps
	input wire logic jack, // Clock select strap
	input wire logic hostBit7, // Host bit-7 level
	input wire logic ale, // Address strobe
	input wire logic bit7Out, // Device bit-7 value
	input wire logic bit7OeN, // Device bit-7 enable
	input wire logic intOeN, // Device interrupt enable
	output pin_in_t pinIn // Resolved pin levels
);
	// Interrupt wire has a pull-up; the strap only drives it in hardware mode
	always_comb begin
		pinIn.busIfaceSelect = sel;
		pinIn.tristateResetPin = tst;
		pinIn.txModeSelect1 = txm[0];
		pinIn.txModeSelect2 = txm[1];
		pinIn.bit7 = bit7OeN ? hostBit7 : bit7Out;
		pinIn.jitterClkSelect0 = (sel == 2'h3) ? jack : intOeN;
		pinIn.addrLatch = ale;
	end
endmodule
`default_nettype wire

// ---- dv/tb_host_port_mode_select.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_host_port_mode_select;
	import host_port_mode_select_pkg::*;
	logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, bit7Out, bit7OeN, intOut, intOeN;
	logic cd7Out = 0, cd7Drive = 0, coreData7In, coreAddr7, regReset, irq;
	logic [7:0] eventIn = 8'h00;
	logic [1:0] sel = 2'h0, txm = 2'h0;
	logic tst = 0, jack = 0, hostBit7 = 0, ale = 0;
	pin_in_t pinIn;
	cfg_out_t cfgOut;
	int failures = 0, n_compared = 0;
	always #5 core_clk = ~core_clk;
	host_pins_model host(.sel(sel), .tst(tst), .txm(txm), .jack(jack),
		.hostBit7(hostBit7), .ale(ale), .bit7Out(bit7Out),
		.bit7OeN(bit7OeN), .intOeN(intOeN), .pinIn(pinIn));
	host_port_mode_select dut(.core_clk(core_clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pinIn(pinIn), .bit7Out(bit7Out),
		.bit7OeN(bit7OeN), .intOut(intOut), .intOeN(intOeN),
		.coreData7Out(cd7Out), .coreData7Drive(cd7Drive),
		.coreData7In(coreData7In), .coreAddr7(coreAddr7),
		.eventIn(eventIn), .cfgOut(cfgOut), .regReset(regReset), .irq(irq));
	task automatic end_sim();
		$display("Compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Waits for pready under a bound so a dead slave cannot hang the run
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 20) begin
			failures++;
			end_sim();
		end
	endtask
	task automatic t_regs();
		apb(0, 12'h000, 0); chk("status", 0, rd);
		apb(1, 12'h004, 32'h0000_005A); apb(0, 12'h004, 0);
		chk("enable", 32'h0000_005A, rd);
		apb(0, 12'h008, 0); chk("clear", 0, rd);
		apb(0, 12'h020, 0); chk("unmapped", 1, er);
	endtask
	task automatic t_irq();
		apb(1, 12'h004, 32'h0000_0001);
		@(posedge core_clk) eventIn <= 8'h03;
		@(posedge core_clk) eventIn <= 8'h00;
		cyc(2); chk("irq", 1, irq); chk("intOeN", 0, intOeN);
		chk("intOut", 0, intOut);
		apb(0, 12'h000, 0); chk("status", 32'h0000_0003, rd);
		apb(1, 12'h008, 32'h0000_0001); cyc(1);
		chk("masked", 1, intOeN);
		apb(1, 12'h004, 32'h0000_0002); cyc(1);
		chk("irq2", 1, irq);
	endtask
	task automatic t_hw();
		sel <= 2'h3; hostBit7 <= 1; txm <= 2'h3; jack <= 1; cyc(5);
		chk("term", 1, cfgOut.rxTermDisable);
		chk("txMode", 3, cfgOut.txMode);
		chk("jack", 1, cfgOut.jitterClkSelect0);
		chk("intOff", 1, intOeN);
		hostBit7 <= 0; txm <= 2'h0; cyc(5);
		chk("termOff", 0, cfgOut.rxTermDisable);
		chk("txMode0", 0, cfgOut.txMode);
	endtask
	task automatic t_bus();
		sel <= 2'h1; jack <= 0; cd7Drive <= 1; cd7Out <= 1; cyc(5);
		chk("drive", 0, bit7OeN); chk("bit7", 1, bit7Out);
		sel <= 2'h0; ale <= 1; hostBit7 <= 1; cd7Out <= 0; cyc(6);
		chk("addrOe", 1, bit7OeN); chk("addr7", 1, coreAddr7);
		ale <= 0; cd7Drive <= 0; hostBit7 <= 0; cyc(6);
		chk("data7", 0, coreData7In);
		sel <= 2'h2; cd7Drive <= 1; cyc(5);
		chk("serial", 1, bit7OeN);
	endtask
	task automatic t_tst();
		int pulses;
		sel <= 2'h1; apb(1, 12'h004, 32'h0000_00FF);
		tst <= 1; pulses = 0;
		repeat (8) begin
			@(posedge core_clk);
			if (regReset === 1'b1) pulses++;
		end
		cyc(1); chk("pulses", 1, pulses);
		chk("bit7Z", 1, bit7OeN); chk("intZ", 1, intOeN);
		chk("trisAll", 1, cfgOut.tristateAll);
		apb(0, 12'h004, 0); chk("enRst", 0, rd);
		tst <= 0; cyc(5); chk("bit7On", 0, bit7OeN);
	endtask
	// Register txMode outside hardware mode, straps override it inside
	task automatic t_ctrl();
		cd7Out <= 1;
		apb(1, 12'h00C, 32'h0000_0002);
		apb(0, 12'h00C, 0);
		chk("ctrl", 32'h0000_0002, rd);
		chk("txModeReg", 2, cfgOut.txMode);
		apb(0, 12'h010, 0);
		chk("pins", 32'h0000_0059, rd);
		sel <= 2'h3;
		txm <= 2'h1;
		cyc(5);
		chk("txModePin", 1, cfgOut.txMode);
	endtask
	initial begin
		cyc(10);
		reset <= 0;
		cyc(1);
		t_regs();
		t_irq();
		t_hw();
		t_bus();
		t_tst();
		t_ctrl();
		end_sim();
	end
endmodule
`default_nettype wire
